/* File: shared/umbt_pkg.sv */
// umbt_pkg: register map, field layouts, modes and state record of the
// serial port mode, baud and idle time-out configuration slice.
// assumes a 32-bit register port with byte addresses on 8 bits.
`default_nettype none
package umbt_pkg;

    // register byte offsets
    localparam logic [7:0] UMBT_OFS_TOR  = 8'h20;
    localparam logic [7:0] UMBT_OFS_BAUD = 8'h24;
    localparam logic [7:0] UMBT_OFS_IR   = 8'h28;
    localparam logic [7:0] UMBT_OFS_ALT  = 8'h2C;
    localparam logic [7:0] UMBT_OFS_FUN  = 8'h30;
    localparam logic [7:0] UMBT_OFS_STAT = 8'h3C;

    // reset values
    localparam logic [31:0] UMBT_TOR_RST  = 32'h0000_0000;
    localparam logic [31:0] UMBT_BAUD_RST = 32'h0F00_0000;
    localparam logic [31:0] UMBT_IR_RST   = 32'h0000_0040;
    localparam logic [31:0] UMBT_ALT_RST  = 32'h0000_000C;
    localparam logic [31:0] UMBT_FUN_RST  = 32'h0000_0000;

    // writable bits; reserved bits stay zero
    localparam logic [31:0] UMBT_TOR_WMASK  = 32'h0000_FFFF;
    localparam logic [31:0] UMBT_BAUD_WMASK = 32'h3F00_FFFF;
    localparam logic [31:0] UMBT_IR_WMASK   = 32'h0000_0062;
    localparam logic [31:0] UMBT_ALT_WMASK  = 32'hFF00_87CF;
    localparam logic [31:0] UMBT_FUN_WMASK  = 32'h0000_0003;

    // bit-time prescale factor when no extra divider is in use
    localparam int          UMBT_M_DEFAULT = 16;
    localparam logic [3:0]  UMBT_M_DEF_LAST = 4'(UMBT_M_DEFAULT - 1);
    localparam logic [3:0]  UMBT_M_ONE_LAST = 4'h0;

    // port personality codes
    localparam logic [1:0] UMBT_PERS_UART  = 2'h0;
    localparam logic [1:0] UMBT_PERS_LIN   = 2'h1;
    localparam logic [1:0] UMBT_PERS_IRDA  = 2'h2;
    localparam logic [1:0] UMBT_PERS_RS485 = 2'h3;

    typedef struct packed {
        logic [15:0] rsvd;
        logic [7:0]  tx_gap_length;
        logic [7:0]  idle_compare_value;
    } umbt_tor_t;

    typedef struct packed {
        logic [1:0]  rsvd_hi;
        logic        xdiv_enable;
        logic        xdiv_one;
        logic [3:0]  xdiv_value;
        logic [7:0]  rsvd_mid;
        logic [15:0] baud_divisor;
    } umbt_baud_t;

    typedef struct packed {
        logic [24:0] rsvd_hi;
        logic        infrared_rx_invert;
        logic        infrared_tx_invert;
        logic [2:0]  rsvd_mid;
        logic        tx_direction;
        logic        rsvd_lo;
    } umbt_ir_t;

    typedef struct packed {
        logic [7:0]  addr_match;
        logic [7:0]  rsvd_hi;
        logic        multidrop_addr_detect_enable;
        logic [3:0]  rsvd_mid;
        logic        auto_direction_mode;
        logic        auto_address_mode;
        logic        normal_multidrop_mode;
        logic        lin_tx_break;
        logic        lin_rx_enable;
        logic [1:0]  rsvd_lo;
        logic [3:0]  break_length;
    } umbt_alt_t;

    typedef struct packed {
        logic [29:0] rsvd;
        logic [1:0]  port_personality;
    } umbt_fun_t;

    typedef struct packed {
        logic [15:0] rsvd_hi;
        logic [7:0]  idle_count;
        logic [4:0]  rsvd_lo;
        logic        break_busy;
        logic        gap_busy;
        logic        idle_flag;
    } umbt_stat_t;

    // mode settings handed to the serial engines
    typedef struct packed {
        logic [1:0] port_personality;
        logic       lin_rx_enable;
        logic [7:0] addr_match;
        logic       multidrop_addr_detect_enable;
        logic       auto_direction_mode;
        logic       auto_address_mode;
        logic       normal_multidrop_mode;
    } umbt_mode_t;

    typedef enum logic [1:0] {
        UMBT_BRK_IDLE = 2'b01,
        UMBT_BRK_SEND = 2'b10
    } umbt_brk_t;

    typedef enum logic [1:0] {
        UMBT_GAP_IDLE = 2'b01,
        UMBT_GAP_WAIT = 2'b10
    } umbt_gap_t;

    typedef struct packed {
        umbt_tor_t   tor;
        umbt_baud_t  baud;
        umbt_ir_t    ir;
        umbt_alt_t   alt;
        umbt_fun_t   fun;
        logic [31:0] rdata;
        logic [16:0] presc;
        logic [3:0]  mcnt;
        logic        sample_tick;
        logic        bit_tick;
        logic [7:0]  idle_cnt;
        logic        idle_flag;
        umbt_brk_t   brk_st;
        logic [3:0]  brk_cnt;
        umbt_gap_t   gap_st;
        logic [7:0]  gap_cnt;
        logic [1:0]  ir_sync;
        logic        ir_rx_q;
        logic        ir_tx_q;
    } umbt_state_t;

endpackage
`default_nettype wire

/* File: src/umbt_cfg.sv */
// umbt_cfg: mode, baud generator, idle time-out and transmit gap / break
// timing of a multi-function serial port.
// assumes the receive buffer, shifters and interrupt enables live outside and
// run on clk; only the infrared receive pin is asynchronous.
`timescale 1ns/100ps
`default_nettype none

module umbt_cfg
    import umbt_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,

    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,

    // receive buffer events
    input  wire logic        rx_word_push,
    input  wire logic        rx_buf_empty,
    input  wire logic        rx_buf_read,
    input  wire logic        idle_irq_enable,
    output logic             idle_timeout_flag,
    output logic             idle_timeout_irq,

    // baud rate enables
    output logic             sample_tick,
    output logic             bit_tick,

    // transmit pacing
    input  wire logic        tx_char_done,
    output logic             tx_gap_hold,
    output logic             lin_break_active,

    // infrared line
    input  wire logic        ir_rx_pin,
    output logic             ir_rx_data,
    output logic             ir_rx_enable,
    input  wire logic        ir_tx_data,
    output logic             ir_tx_pin,
    output logic             ir_tx_enable,

    // mode settings
    output umbt_mode_t       mode_cfg
);

    umbt_state_t s_r;
    umbt_state_t s_nxt;

    // last value of the bit-time prescale counter, i.e. M minus one
    function automatic logic [3:0] m_last(input umbt_baud_t b);
        logic [3:0] r;
        r = UMBT_M_DEF_LAST;
        if (b.xdiv_one)
        begin
            r = UMBT_M_ONE_LAST;
        end
        else if (b.xdiv_enable)
        begin
            r = b.xdiv_value;
        end
        return r;
    endfunction

    logic        wr_tor;
    logic        wr_baud;
    logic        wr_ir;
    logic        wr_alt;
    logic        wr_fun;
    logic [16:0] presc_last;
    logic        presc_wrap;
    logic        rx_activity;
    logic        is_lin;
    logic        is_irda;
    umbt_stat_t  stat;

    assign wr_tor      = reg_wr && (reg_addr == UMBT_OFS_TOR);
    assign wr_baud     = reg_wr && (reg_addr == UMBT_OFS_BAUD);
    assign wr_ir       = reg_wr && (reg_addr == UMBT_OFS_IR);
    assign wr_alt      = reg_wr && (reg_addr == UMBT_OFS_ALT);
    assign wr_fun      = reg_wr && (reg_addr == UMBT_OFS_FUN);
    // divisor plus two clocks per prescale period
    assign presc_last  = {1'b0, s_r.baud.baud_divisor} + 17'h0_0001;
    assign presc_wrap  = (s_r.presc == presc_last);
    assign rx_activity = rx_word_push || rx_buf_read;
    assign is_lin      = (s_r.fun.port_personality == UMBT_PERS_LIN);
    assign is_irda     = (s_r.fun.port_personality == UMBT_PERS_IRDA);

    always_comb
    begin
        stat            = '0;
        stat.idle_count = s_r.idle_cnt;
        stat.break_busy = (s_r.brk_st == UMBT_BRK_SEND);
        stat.gap_busy   = (s_r.gap_st == UMBT_GAP_WAIT);
        stat.idle_flag  = s_r.idle_flag;
    end

    always_comb
    begin
        s_nxt = s_r;

        // register writes; reserved bits forced to zero
        if (wr_tor)
        begin
            s_nxt.tor = umbt_tor_t'(reg_wdata & UMBT_TOR_WMASK);
        end
        if (wr_baud)
        begin
            s_nxt.baud = umbt_baud_t'(reg_wdata & UMBT_BAUD_WMASK);
        end
        if (wr_ir)
        begin
            s_nxt.ir = umbt_ir_t'(reg_wdata & UMBT_IR_WMASK);
        end
        if (wr_alt)
        begin
            s_nxt.alt = umbt_alt_t'(reg_wdata & UMBT_ALT_WMASK);
        end
        if (wr_fun)
        begin
            s_nxt.fun = umbt_fun_t'(reg_wdata & UMBT_FUN_WMASK);
        end

        // read data stand exactly one cycle after the strobe
        s_nxt.rdata = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                UMBT_OFS_TOR:  s_nxt.rdata = s_r.tor;
                UMBT_OFS_BAUD: s_nxt.rdata = s_r.baud;
                UMBT_OFS_IR:   s_nxt.rdata = s_r.ir;
                UMBT_OFS_ALT:  s_nxt.rdata = s_r.alt;
                UMBT_OFS_FUN:  s_nxt.rdata = s_r.fun;
                UMBT_OFS_STAT: s_nxt.rdata = stat;
                default:       s_nxt.rdata = '0;
            endcase
        end

        // baud generator: prescaler, then M stage
        s_nxt.sample_tick = 1'b0;
        s_nxt.bit_tick    = 1'b0;
        if (wr_baud)
        begin
            // restart so a new divisor never sees a stale count
            s_nxt.presc = '0;
            s_nxt.mcnt  = '0;
        end
        else if (presc_wrap)
        begin
            s_nxt.presc       = '0;
            s_nxt.sample_tick = 1'b1;
            if (s_r.mcnt >= m_last(s_r.baud))
            begin
                s_nxt.mcnt     = '0;
                s_nxt.bit_tick = 1'b1;
            end
            else
            begin
                s_nxt.mcnt = s_r.mcnt + 4'h1;
            end
        end
        else
        begin
            s_nxt.presc = s_r.presc + 17'h0_0001;
        end

        // receive idle counter
        if (rx_activity || rx_buf_empty)
        begin
            s_nxt.idle_cnt = '0;
        end
        else if (s_r.bit_tick && (s_r.idle_cnt != s_r.tor.idle_compare_value))
        begin
            s_nxt.idle_cnt = s_r.idle_cnt + 8'h01;
        end

        // time-out flag: every clear cause excludes the set, so none is lost
        if (!rx_buf_empty && !rx_activity
            && (s_r.idle_cnt == s_r.tor.idle_compare_value))
        begin
            s_nxt.idle_flag = 1'b1;
        end
        else if (rx_word_push || rx_buf_empty)
        begin
            s_nxt.idle_flag = 1'b0;
        end
        else if (rx_buf_read)
        begin
            s_nxt.idle_flag = 1'b0;
        end

        // inter-character gap
        case (s_r.gap_st)
            UMBT_GAP_IDLE:
            begin
                if (tx_char_done && (s_r.tor.tx_gap_length != 8'h00))
                begin
                    s_nxt.gap_st  = UMBT_GAP_WAIT;
                    s_nxt.gap_cnt = '0;
                end
            end
            UMBT_GAP_WAIT:
            begin
                if (s_r.bit_tick)
                begin
                    if (s_r.gap_cnt + 8'h01 >= s_r.tor.tx_gap_length)
                    begin
                        s_nxt.gap_st = UMBT_GAP_IDLE;
                    end
                    else
                    begin
                        s_nxt.gap_cnt = s_r.gap_cnt + 8'h01;
                    end
                end
            end
            default:
            begin
                s_nxt.gap_st = UMBT_GAP_IDLE;
            end
        endcase

        // LIN break: starts on a bit boundary, lasts length plus one bits
        case (s_r.brk_st)
            UMBT_BRK_IDLE:
            begin
                if (s_r.alt.lin_tx_break && is_lin && s_r.bit_tick)
                begin
                    s_nxt.brk_st  = UMBT_BRK_SEND;
                    s_nxt.brk_cnt = '0;
                end
            end
            UMBT_BRK_SEND:
            begin
                if (!s_r.alt.lin_tx_break || !is_lin)
                begin
                    // software withdrew the request or left the LIN personality
                    s_nxt.brk_st = UMBT_BRK_IDLE;
                end
                else if (s_r.bit_tick)
                begin
                    if (s_r.brk_cnt == s_r.alt.break_length)
                    begin
                        s_nxt.brk_st = UMBT_BRK_IDLE;
                        // a write in this cycle keeps its own value
                        if (!wr_alt)
                        begin
                            s_nxt.alt.lin_tx_break = 1'b0;
                        end
                    end
                    else
                    begin
                        s_nxt.brk_cnt = s_r.brk_cnt + 4'h1;
                    end
                end
            end
            default:
            begin
                s_nxt.brk_st = UMBT_BRK_IDLE;
            end
        endcase

        // infrared paths; disabled direction idles with no pulse
        s_nxt.ir_sync = {s_r.ir_sync[0], ir_rx_pin};
        s_nxt.ir_rx_q = 1'b0;
        if (is_irda && !s_r.ir.tx_direction)
        begin
            s_nxt.ir_rx_q = s_r.ir_sync[1] ^ s_r.ir.infrared_rx_invert;
        end
        s_nxt.ir_tx_q = s_r.ir.infrared_tx_invert;
        if (is_irda && s_r.ir.tx_direction)
        begin
            s_nxt.ir_tx_q = ir_tx_data ^ s_r.ir.infrared_tx_invert;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_r             <= '0;
            s_r.tor         <= umbt_tor_t'(UMBT_TOR_RST);
            s_r.baud        <= umbt_baud_t'(UMBT_BAUD_RST);
            s_r.ir          <= umbt_ir_t'(UMBT_IR_RST);
            s_r.alt         <= umbt_alt_t'(UMBT_ALT_RST);
            s_r.fun         <= umbt_fun_t'(UMBT_FUN_RST);
            s_r.brk_st      <= UMBT_BRK_IDLE;
            s_r.gap_st      <= UMBT_GAP_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign reg_rdata         = s_r.rdata;
    assign idle_timeout_flag = s_r.idle_flag;
    assign idle_timeout_irq  = s_r.idle_flag && idle_irq_enable;
    assign sample_tick       = s_r.sample_tick;
    assign bit_tick          = s_r.bit_tick;
    assign tx_gap_hold       = (s_r.gap_st == UMBT_GAP_WAIT);
    assign lin_break_active  = (s_r.brk_st == UMBT_BRK_SEND);
    assign ir_rx_data        = s_r.ir_rx_q;
    assign ir_tx_pin         = s_r.ir_tx_q;
    assign ir_rx_enable      = is_irda && !s_r.ir.tx_direction;
    assign ir_tx_enable      = is_irda && s_r.ir.tx_direction;

    // is left to software: all three mode bits pass through unchanged
    assign mode_cfg.port_personality             = s_r.fun.port_personality;
    assign mode_cfg.lin_rx_enable                = s_r.alt.lin_rx_enable;
    assign mode_cfg.addr_match                   = s_r.alt.addr_match;
    assign mode_cfg.multidrop_addr_detect_enable = s_r.alt.multidrop_addr_detect_enable;
    assign mode_cfg.auto_direction_mode          = s_r.alt.auto_direction_mode;
    assign mode_cfg.auto_address_mode            = s_r.alt.auto_address_mode;
    assign mode_cfg.normal_multidrop_mode        = s_r.alt.normal_multidrop_mode;

endmodule
`default_nettype wire

/* File: test/umbt_cfg_properties.sv */
// umbt_cfg_properties: port-level timing checks for the config slice.
// assumes it is bound onto umbt_cfg; one clock, async reset.
`timescale 1ns/100ps
`default_nettype none
module umbt_cfg_properties
    import umbt_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // receive side
    input wire logic        rx_word_push,
    input wire logic        rx_buf_empty,
    input wire logic        rx_buf_read,
    input wire logic        idle_irq_enable,
    input wire logic        idle_timeout_flag,
    input wire logic        idle_timeout_irq,
    // pacing and modes
    input wire logic        sample_tick,
    input wire logic        tx_char_done,
    input wire logic        tx_gap_hold,
    input wire logic        ir_rx_enable,
    input wire logic        ir_tx_enable,
    input wire umbt_mode_t  mode_cfg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // shadow of the gap length, seen only through writes
    logic [7:0] gap_r;
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            gap_r <= 8'h00;
        else if (reg_wr && reg_addr == UMBT_OFS_TOR)
            gap_r <= reg_wdata[15:8];

    chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside its slot");
    chk_irq_gate: assert property (
        idle_timeout_irq == (idle_timeout_flag && idle_irq_enable))
        else $error("time-out irq not flag and enable");
    chk_flag_clear: assert property (
        (rx_word_push || rx_buf_read || rx_buf_empty) |=> !idle_timeout_flag)
        else $error("time-out flag not cleared");
    chk_flag_cause: assert property ($rose(idle_timeout_flag) |-> !$past(rx_buf_empty))
        else $error("time-out flag with empty buffer");
    chk_ir_half: assert property (!(ir_rx_enable && ir_tx_enable))
        else $error("infrared both directions on");
    chk_tick_space: assert property (sample_tick |=> !sample_tick)
        else $error("sample ticks back to back");
    chk_gap_start: assert property (
        tx_char_done && gap_r != 8'h00 && !tx_gap_hold |=> tx_gap_hold)
        else $error("gap hold not started");
    chk_gap_zero: assert property (
        tx_char_done && gap_r == 8'h00 && !tx_gap_hold |=> !tx_gap_hold)
        else $error("gap hold with zero length");
    chk_pers_write: assert property (
        reg_wr && reg_addr == UMBT_OFS_FUN |=>
        mode_cfg.port_personality == $past(reg_wdata[1:0]))
        else $error("personality not taken from write");
endmodule

bind umbt_cfg umbt_cfg_properties umbt_cfg_properties_inst (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_word_push(rx_word_push), .rx_buf_empty(rx_buf_empty), .rx_buf_read(rx_buf_read),
    .idle_irq_enable(idle_irq_enable), .idle_timeout_flag(idle_timeout_flag),
    .idle_timeout_irq(idle_timeout_irq), .sample_tick(sample_tick),
    .tx_char_done(tx_char_done), .tx_gap_hold(tx_gap_hold),
    .ir_rx_enable(ir_rx_enable), .ir_tx_enable(ir_tx_enable), .mode_cfg(mode_cfg));
`default_nettype wire

/* File: test/umbt_remote.sv */
// umbt_remote: remote infrared node driving the receive pin.
// assumes the bench samples the pin; slow square wave while listened to.
`timescale 1ns/100ps
`default_nettype none
module umbt_remote
(
    // clock
    input wire logic clk,
    // infrared line
    input wire logic rx_open,
    output logic     line
);
    logic [2:0] cnt_r = 3'h0;
    initial line = 1'b1;
    // unheard line toggles every cycle so no stale level looks valid
    always @(posedge clk)
    begin
        cnt_r <= cnt_r + 3'h1;
        if (!rx_open || cnt_r == 3'h0)
            line <= !line;
    end
endmodule
`default_nettype wire

/* File: test/uart_mode_baud_timeout_cfg_test.sv */
// uart_mode_baud_timeout_cfg_test: self-checking bench of the config slice.
// assumes umbt_cfg, umbt_remote and the checker bind are compiled with it.
`timescale 1ns/100ps
`default_nettype none
module uart_mode_baud_timeout_cfg_test
    import umbt_pkg::*;
;
    logic        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
    logic        rx_word_push = 1'b0, rx_buf_empty = 1'b1, rx_buf_read = 1'b0;
    logic        idle_irq_enable = 1'b0, tx_char_done = 1'b0, ir_tx_data = 1'b0;
    logic        idle_timeout_flag, idle_timeout_irq, sample_tick, bit_tick;
    logic        tx_gap_hold, lin_break_active, ir_rx_pin, ir_rx_data;
    logic        ir_rx_enable, ir_tx_pin, ir_tx_enable;
    umbt_mode_t  mode_cfg;
    int          failures = 0, n_compared = 0, n, k;
    logic [31:0] rnd = 32'h0000_003D;
    logic [31:0] mdl [5] = '{UMBT_TOR_RST, UMBT_BAUD_RST, UMBT_IR_RST, UMBT_ALT_RST,
                             UMBT_FUN_RST};
    localparam logic [31:0] MSK [5] = '{UMBT_TOR_WMASK, UMBT_BAUD_WMASK, UMBT_IR_WMASK,
                                        UMBT_ALT_WMASK, UMBT_FUN_WMASK};
    // random values kept inside what software may program
    localparam logic [31:0] SWM [5] = '{32'hFFFF_FFFF, 32'hCFFF_FFFF, 32'hFFFF_FFFF,
                                        32'hFFFF_FE7F, 32'hFFFF_FFFF};
    always #4 clk = ~clk;

    umbt_cfg umbt_cfg_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_word_push(rx_word_push), .rx_buf_empty(rx_buf_empty),
        .rx_buf_read(rx_buf_read), .idle_irq_enable(idle_irq_enable),
        .idle_timeout_flag(idle_timeout_flag), .idle_timeout_irq(idle_timeout_irq),
        .sample_tick(sample_tick), .bit_tick(bit_tick), .tx_char_done(tx_char_done),
        .tx_gap_hold(tx_gap_hold), .lin_break_active(lin_break_active),
        .ir_rx_pin(ir_rx_pin), .ir_rx_data(ir_rx_data), .ir_rx_enable(ir_rx_enable),
        .ir_tx_data(ir_tx_data), .ir_tx_pin(ir_tx_pin), .ir_tx_enable(ir_tx_enable),
        .mode_cfg(mode_cfg));
    umbt_remote umbt_remote_inst (.clk(clk), .rx_open(ir_rx_enable), .line(ir_rx_pin));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        // write behind a write lets one edge pass, so no strobe is set twice in a step
        if (reg_wr === 1'b1)
            @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a >= 8'h20 && a <= 8'h30 && a[1:0] == 2'b00)
            mdl[(a - 8'h20) >> 2] = v & MSK[(a - 8'h20) >> 2];
    endtask
    task automatic rdc(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = (a >= 8'h20 && a <= 8'h30 && a[1:0] == 2'b00) ? mdl[(a - 8'h20) >> 2] : 32'h0;
        chk(reg_rdata, d, "register read");
    endtask
    // bit ticks seen while the gap hold (0) or break (1) is up
    task automatic count_high(input int sel, output int t);
        k = 0;
        t = 0;
        while ((sel == 0 ? tx_gap_hold : lin_break_active) !== 1'b1 && k < 500)
        begin
            @(posedge clk);
            k++;
        end
        while ((sel == 0 ? tx_gap_hold : lin_break_active) === 1'b1 && k < 2000)
        begin
            if (bit_tick === 1'b1)
                t++;
            @(posedge clk);
            k++;
        end
    endtask
    task automatic period(output int p);
        // skip the write cycle, whose tick may still belong to the old rate
        @(posedge clk);
        k = 0;
        while (bit_tick !== 1'b1 && k < 5000)
        begin
            @(posedge clk);
            k++;
        end
        @(posedge clk);
        p = 1;
        while (bit_tick !== 1'b1 && p < 5000)
        begin
            @(posedge clk);
            p++;
        end
    endtask
    task automatic pulse_done;
        tx_char_done <= 1'b1;
        @(posedge clk);
        tx_char_done <= 1'b0;
    endtask
    task automatic test_done;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #(8 * 20000);
        failures++;
        test_done();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 5; i++)
            rdc(8'h20 + 8'(4 * i));
        for (int i = 0; i < 5; i++)
        begin
            rnd = xs(rnd);
            wr(8'h20 + 8'(4 * i), rnd & SWM[i]);
            rdc(8'h20 + 8'(4 * i));
        end
        wr(8'h40, rnd);
        wr(UMBT_OFS_STAT, rnd);
        rdc(8'h40);
        $display("registers done");
        wr(UMBT_OFS_FUN, 32'h0000_0000);
        wr(UMBT_OFS_BAUD, 32'h0000_0001);
        period(n);
        chk(32'(n), 32'd48, "bit period default");
        wr(UMBT_OFS_BAUD, 32'h2800_0001);
        period(n);
        chk(32'(n), 32'd27, "bit period extra");
        wr(UMBT_OFS_BAUD, 32'h1000_0003);
        period(n);
        chk(32'(n), 32'd5, "bit period one");
        chk({31'h0, sample_tick}, 32'h1, "sample tick at M one");
        $display("baud done");
        wr(UMBT_OFS_TOR, 32'h0000_0028);
        for (int c = 0; c < 3; c++)
        begin
            idle_irq_enable <= (c != 1);
            rx_buf_empty <= 1'b0;
            rx_word_push <= 1'b1;
            @(posedge clk);
            rx_word_push <= 1'b0;
            @(posedge clk);
            n = 0;
            k = 0;
            while (idle_timeout_flag !== 1'b1 && k < 1000)
            begin
                if (bit_tick === 1'b1)
                    n++;
                @(posedge clk);
                k++;
            end
            chk(32'(n), 32'd40, "ticks to time-out");
            chk({31'h0, idle_timeout_irq}, {31'h0, c != 1}, "time-out irq");
            if (c == 0)
                rx_buf_read <= 1'b1;
            else if (c == 1)
                rx_buf_empty <= 1'b1;
            else
                rx_word_push <= 1'b1;
            @(posedge clk);
            rx_buf_read <= 1'b0;
            rx_word_push <= 1'b0;
            @(posedge clk);
            chk({31'h0, idle_timeout_flag}, 32'h0, "time-out flag clear");
        end
        rx_buf_empty <= 1'b1;
        $display("time-out done");
        wr(UMBT_OFS_TOR, 32'h0000_0328);
        pulse_done();
        count_high(0, n);
        chk(32'(n), 32'd3, "gap length");
        wr(UMBT_OFS_TOR, 32'h0000_0028);
        pulse_done();
        n = 0;
        repeat (10)
        begin
            @(posedge clk);
            if (tx_gap_hold !== 1'b0)
                n++;
        end
        chk(32'(n), 32'd0, "zero gap");
        $display("gap done");
        wr(UMBT_OFS_FUN, 32'h0000_0001);
        for (int b = 0; b < 13; b += 12)
        begin
            wr(UMBT_OFS_ALT, 32'h0000_00C0 | 32'(b));
            count_high(1, n);
            chk(32'(n), 32'(b + 1), "break length");
            mdl[3][7] = 1'b0;
            rdc(UMBT_OFS_ALT);
            chk({31'h0, mode_cfg.lin_rx_enable}, 32'h1, "lin receive");
        end
        $display("break done");
        wr(UMBT_OFS_FUN, 32'h0000_0003);
        for (int m = 0; m < 2; m++)
        begin
            rnd = xs(rnd);
            wr(UMBT_OFS_ALT, {rnd[31:24], 8'h00, 16'h8400 | (16'h0100 << m)});
            @(posedge clk);
            chk(32'(mode_cfg), 32'({2'h3, 1'b0, rnd[31:24], 2'b11, m[0], !m[0]}),
                "rs485 modes");
        end
        $display("rs485 done");
        wr(UMBT_OFS_FUN, 32'h0000_0002);
        wr(UMBT_OFS_IR, 32'h0000_0040);
        @(posedge clk);
        chk({30'h0, ir_rx_enable, ir_tx_enable}, 32'h2, "infrared receive dir");
        repeat (20) @(posedge clk);
        repeat (3)
        begin
            @(ir_rx_pin);
            repeat (5) @(posedge clk);
            chk({31'h0, ir_rx_data}, {31'h0, !ir_rx_pin}, "infrared rx invert");
        end
        wr(UMBT_OFS_IR, 32'h0000_0022);
        @(posedge clk);
        chk({30'h0, ir_rx_enable, ir_tx_enable}, 32'h1, "infrared send dir");
        repeat (4)
        begin
            rnd = xs(rnd);
            ir_tx_data <= rnd[0];
            repeat (2) @(posedge clk);
            chk({31'h0, ir_tx_pin}, {31'h0, !rnd[0]}, "infrared tx invert");
        end
        $display("infrared done");
        test_done();
    end
endmodule
`default_nettype wire
